// ---- src/sfs_pkg.sv ----
// sfs_pkg: shared constants and types of the serial flash front end.
// assumes nothing of its surroundings; used by sfs_front_end, its checker and tb.
package sfs_pkg;
  localparam int SECTOR_COUNT = 64;
  localparam int PAGES_PER_SECTOR = 1024;
  localparam int PAGE_BYTES = 256;
  localparam int ADDR_W = 24;
  localparam int SECTOR_W = 6;
  localparam int PAGE_W = 10;
  localparam int BYTE_W = 8;
  localparam int SECTOR_LSB = 18;
  localparam int PAGE_LSB = 8;
  localparam int GUARD_W = 3;
  localparam int MAX_SCK_MHZ = 54;
  localparam int FIFO_DEPTH = 8;

  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_ZONE_WIPE = 8'hD8;
  localparam logic [7:0] CMD_FULL_WIPE = 8'hC7;
  localparam logic [8:0] PAGE_MAX_COUNT = 9'h100;
  localparam logic [2:0] RESET_BITCNT = 3'h0;

  typedef enum logic [1:0] {
    SFS_OP_PAGE_WRITE = 2'h0,
    SFS_OP_ZONE_WIPE  = 2'h1,
    SFS_OP_FULL_WIPE  = 2'h2
  } sfs_op_t;

  // one received byte from the link, with its place in the frame
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } sfs_rx_t;

  // one array operation handed to the core
  typedef struct packed {
    sfs_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [8:0]          count;
    logic                fast;
  } sfs_job_t;
endpackage

// ---- src/sfs_fifo.sv ----
// sfs_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock for both ports; depth is a power of two.
`timescale 1ns/100ps
module sfs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              do_wr;
  wire              do_rd;
  wire              full;
  wire              empty;

  assign full      = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty     = (wr_ff == rd_ff);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;
  assign out_data  = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule

// ---- src/sfs_front_end.sv ----
// sfs_front_end: serial link front end of a byte organised serial flash.
// assumes the master drives select, clock, data and pause; the core side
// runs on core_clk and takes array jobs from job_* with its own handshake.
//
// What this block does
// - output bit changes on each falling serial clock edge
// - input bit sampled on each rising serial clock edge
// - select high means deselected and output enable low
// - standby only when deselected and no array cycle busy
// - no command accepted before first select falling edge after power-up
// - pause suspends the exchange without deselecting
// - while paused output released, clock and input ignored
// - logic level protect pin freezes the guard bits
// - boost level on protect pin selects fast program and erase
// - array is 64 sectors of 1024 pages of 256 bytes
// - page write takes one to 256 data bytes
// - zone wipe erases one sector, full wipe the whole array
// - link runs up to 54 MHz serial clock
// - works in clock idle low or idle high modes
// - guard bits mark upper sectors read only, writes refused
`timescale 1ns/100ps
module sfs_front_end (
  // core clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // serial link
  input  wire logic                        spi_clk,
  input  wire logic                        sel_n,
  input  wire logic                        mosi,
  input  wire logic                        pause_n,
  output logic                             miso_o,
  output logic                             miso_oe,
  // protect and boost pin, split by the pad into two levels
  input  wire logic                        protect_n,
  input  wire logic                        boost_level,
  // guard bits from the status store
  input  wire logic [sfs_pkg::GUARD_W-1:0] block_guard_bits,
  input  wire logic                        guard_wr,
  // read data the core supplies for output
  input  wire logic [7:0]                  rd_data,
  // array jobs to the core
  output logic                             job_valid,
  input  wire logic                        job_ready,
  output sfs_pkg::sfs_job_t                job_ff,
  output logic                             job_refused_ff,
  // page data to the core
  output logic                             wdata_valid,
  input  wire logic                        wdata_ready,
  output logic [7:0]                       wdata,
  // power state and current guard bits
  input  wire logic                        array_busy,
  output logic                             standby,
  output logic [sfs_pkg::GUARD_W-1:0]      guard_ff
);
  // link domain: the serial clock only runs inside a frame, so the frame
  // start is taken from select itself, never from a held clock edge.
  wire              pause_act;
  logic [2:0]       bitcnt_ff;
  logic [6:0]       shreg_ff;
  logic             first_ff;
  logic [7:0]       txsh_ff;
  logic             txbit_ff;
  wire  [7:0]       rx_byte;
  wire              byte_done;
  logic [1:0]       sel_wptr_ff;

  assign pause_act = !pause_n && !sel_n;
  assign rx_byte   = {shreg_ff, mosi};
  assign byte_done = (bitcnt_ff == 3'h7);

  // sample on rising edge, frozen while paused
  always_ff @(posedge spi_clk or posedge sel_n) begin
    if (sel_n) begin
      bitcnt_ff <= sfs_pkg::RESET_BITCNT;
      shreg_ff  <= '0;
      first_ff  <= 1'b1;
    end else if (!pause_act) begin
      bitcnt_ff <= bitcnt_ff + 3'h1;
      shreg_ff  <= rx_byte[6:0];
      if (byte_done) begin
        first_ff <= 1'b0;
      end
    end
  end

  // byte hand-off by toggle; two hold slots alternate so a slot stays put
  // for two byte times while the core picks it up at full link rate
  logic             rx_tgl_ff;
  logic [8:0]       rx_hold_ff [2];
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      rx_tgl_ff     <= 1'b0;
      rx_hold_ff[0] <= '0;
      rx_hold_ff[1] <= '0;
    end else if (!sel_n && !pause_act && byte_done) begin
      rx_tgl_ff              <= !rx_tgl_ff;
      rx_hold_ff[!rx_tgl_ff] <= {first_ff, rx_byte};
    end
  end

  // output shifted after falling edge; held while paused
  always_ff @(negedge spi_clk or posedge sel_n) begin
    if (sel_n) begin
      txsh_ff  <= '0;
      txbit_ff <= 1'b0;
    end else if (!pause_act) begin
      if (bitcnt_ff == 3'h0) begin
        txbit_ff <= rd_data[7];
        txsh_ff  <= {rd_data[6:0], 1'b0};
      end else begin
        txbit_ff <= txsh_ff[7];
        txsh_ff  <= {txsh_ff[6:0], 1'b0};
      end
    end
  end
  assign miso_o  = txbit_ff;
  assign miso_oe = !sel_n && !pause_act;

  // core domain: synchronisers
  logic [1:0] sel_sync_ff;
  logic [1:0] tgl_sync_ff;
  logic [1:0] prot_sync_ff;
  logic [1:0] boost_sync_ff;
  logic       tgl_seen_ff;
  logic       sel_prev_ff;
  logic       armed_ff;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // low like sel_prev_ff: select held low through reset is no edge
      sel_sync_ff   <= 2'h0;
      tgl_sync_ff   <= 2'h0;
      prot_sync_ff  <= 2'h3;
      boost_sync_ff <= 2'h0;
    end else begin
      sel_sync_ff   <= {sel_sync_ff[0], sel_n};
      tgl_sync_ff   <= {tgl_sync_ff[0], rx_tgl_ff};
      prot_sync_ff  <= {prot_sync_ff[0], protect_n};
      boost_sync_ff <= {boost_sync_ff[0], boost_level};
    end
  end
  wire sel_low  = !sel_sync_ff[1];
  wire sel_fall = sel_prev_ff && sel_low;
  wire rx_event = tgl_sync_ff[1] != tgl_seen_ff;
  wire [8:0] rx_slot = rx_hold_ff[tgl_sync_ff[1]];

  // nothing is accepted before a select falling edge after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_prev_ff <= 1'b0;
      armed_ff    <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      sel_prev_ff <= sel_sync_ff[1];
      tgl_seen_ff <= tgl_sync_ff[1];
      if (sel_fall) begin
        armed_ff <= 1'b1;
      end
    end
  end

  // received bytes queue up so a slow core does not lose them; the slot
  // named by the synced toggle was written at that same toggle, two synchroniser stages earlier.
  wire             rxq_in_ready;
  wire             rxq_valid;
  logic            rxq_ready;
  wire [8:0]       rxq_data;
  sfs_fifo #(.WIDTH(9), .DEPTH(sfs_pkg::FIFO_DEPTH)) u_rxq (
    .core_clk (core_clk),
    .rst      (rst),
    .in_valid (rx_event && armed_ff),
    .in_ready (rxq_in_ready),
    .in_data  (rx_slot),
    .out_valid(rxq_valid),
    .out_ready(rxq_ready),
    .out_data (rxq_data)
  );
  sfs_pkg::sfs_rx_t rxw;
  assign rxw = sfs_pkg::sfs_rx_t'(rxq_data);

  // guard bits freeze while the protect pin is held low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      guard_ff <= '0;
    end else if (guard_wr && prot_sync_ff[1]) begin
      guard_ff <= block_guard_bits;
    end
  end

  // command parser
  typedef enum logic [3:0] {
    ST_CMD  = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } sfs_st_t;
  sfs_st_t           st_ff;
  sfs_st_t           nxt_st;
  logic [7:0]        cmd_ff;
  logic [1:0]        acnt_ff;
  logic [23:0]       addr_ff;
  logic [8:0]        cnt_ff;
  logic              pend_ff;
  logic [7:0]        wdata_ff;
  logic              wvalid_ff;

  // protected region is the upper 2^(g-1) sectors
  function automatic logic guarded(input logic [2:0] g, input logic [5:0] sec);
    logic [6:0] lim;
    lim = (g == 3'h0) ? 7'h40 : 7'(7'h40 - (7'h1 << (g - 3'h1)));
    return {1'b0, sec} >= lim;
  endfunction

  // sector field sits in the top bits
  wire [5:0] addr_sec = addr_ff[sfs_pkg::SECTOR_LSB +: sfs_pkg::SECTOR_W];
  wire       is_write = (cmd_ff == sfs_pkg::CMD_PAGE_WRITE);
  wire       is_zone  = (cmd_ff == sfs_pkg::CMD_ZONE_WIPE);
  wire       blocked  = wvalid_ff && !wdata_ready;
  wire       full_hit = (guard_ff != 3'h0);

  always_comb begin
    nxt_st    = st_ff;
    rxq_ready = !blocked && !pend_ff;
    if (rxq_valid && rxq_ready) begin
      if (rxw.first) begin
        nxt_st = (rxw.data == sfs_pkg::CMD_FULL_WIPE) ? ST_SKIP :
                 (rxw.data == sfs_pkg::CMD_PAGE_WRITE || rxw.data == sfs_pkg::CMD_ZONE_WIPE ||
                  rxw.data == sfs_pkg::CMD_READ) ? ST_ADDR : ST_SKIP;
      end else begin
        unique case (st_ff)
          ST_CMD:  nxt_st = ST_SKIP;
          ST_ADDR: nxt_st = (acnt_ff == 2'h2) ? (is_write ? ST_DATA : ST_SKIP) : ST_ADDR;
          ST_DATA: nxt_st = ST_DATA;
          ST_SKIP: nxt_st = ST_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff          <= ST_CMD;
      cmd_ff         <= '0;
      acnt_ff        <= '0;
      addr_ff        <= '0;
      cnt_ff         <= '0;
      pend_ff        <= 1'b0;
      job_ff         <= '0;
      job_refused_ff <= 1'b0;
      wdata_ff       <= '0;
      wvalid_ff      <= 1'b0;
    end else begin
      st_ff          <= nxt_st;
      job_refused_ff <= 1'b0;
      if (wvalid_ff && wdata_ready) begin
        wvalid_ff <= 1'b0;
      end
      if (pend_ff && job_ready) begin
        pend_ff <= 1'b0;
      end
      if (rxq_valid && rxq_ready) begin
        if (rxw.first) begin
          cmd_ff  <= rxw.data;
          acnt_ff <= '0;
          cnt_ff  <= '0;
        end else if (st_ff == ST_ADDR) begin
          addr_ff <= {addr_ff[15:0], rxw.data};
          acnt_ff <= acnt_ff + 2'h1;
        end else if (st_ff == ST_DATA && cnt_ff != sfs_pkg::PAGE_MAX_COUNT) begin
          wdata_ff  <= rxw.data;
          wvalid_ff <= 1'b1;
          cnt_ff    <= cnt_ff + 9'h1;
        end
      end
      // jobs are issued once deselected and every byte of the frame, still
      // crossing or queued, has been parsed
      if (sel_sync_ff[1] && st_ff != ST_CMD && !rx_event && !rxq_valid && !pend_ff) begin
        st_ff <= ST_CMD;
        if (st_ff == ST_SKIP && cmd_ff == sfs_pkg::CMD_FULL_WIPE) begin
          // full wipe refused if any sector is guarded
          job_ff         <= '{sfs_pkg::SFS_OP_FULL_WIPE, '0, 9'h0, boost_sync_ff[1]};
          pend_ff        <= !full_hit;
          job_refused_ff <= full_hit;
          cmd_ff         <= '0;
        end else if ((is_zone && st_ff == ST_SKIP) || (is_write && st_ff == ST_DATA &&
                     cnt_ff != 9'h0)) begin
          // boost level marks the job fast
          job_ff  <= '{is_zone ? sfs_pkg::SFS_OP_ZONE_WIPE : sfs_pkg::SFS_OP_PAGE_WRITE,
                       addr_ff, cnt_ff, boost_sync_ff[1]};
          pend_ff        <= !guarded(guard_ff, addr_sec);
          job_refused_ff <= guarded(guard_ff, addr_sec);
          cmd_ff         <= '0;
        end
      end
    end
  end

  assign job_valid   = pend_ff;
  assign wdata_valid = wvalid_ff;
  assign wdata       = wdata_ff;
  // standby once deselected, the array is idle and no job is pending
  assign standby     = !sel_low && !array_busy && !pend_ff;
endmodule

// ---- sim/sfs_front_end_properties.sv ----
// sfs_front_end_properties: port-level checker for the serial front end.
// assumes core_clk domain sampling; link pins are sampled as plain levels.
`timescale 1ns/100ps
module sfs_front_end_properties (
  // clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst,
  // serial link
  input wire logic                        sel_n,
  input wire logic                        pause_n,
  input wire logic                        miso_oe,
  // protect pin and guards
  input wire logic                        protect_n,
  input wire logic [sfs_pkg::GUARD_W-1:0] block_guard_bits,
  input wire logic                        guard_wr,
  input wire logic [sfs_pkg::GUARD_W-1:0] guard_ff,
  // core side
  input wire logic                        job_valid,
  input wire logic                        job_ready,
  input wire sfs_pkg::sfs_job_t           job_ff,
  input wire logic                        wdata_valid,
  input wire logic                        wdata_ready,
  input wire logic [7:0]                  wdata,
  input wire logic                        array_busy,
  input wire logic                        standby
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // first sector of the read-only region; all-ones guard covers everything
  wire logic [6:0] guard_base = 7'h40 - (7'h01 << (guard_ff - 3'h1));
  wire logic       guarded    = (guard_ff != 3'h0) &&
                                ({1'b0, job_ff.addr[23:18]} >= guard_base);
  wire logic       is_full    = job_ff.op == sfs_pkg::SFS_OP_FULL_WIPE;

  // synchronisers need a few cycles before a level counts as seen
  sequence prot_open;  protect_n[*4]; endsequence
  sequence prot_shut;  (!protect_n)[*4]; endsequence
  sequence idle_run;   (sel_n && !array_busy && !job_valid)[*4]; endsequence
  sequence active_run; (!sel_n || array_busy)[*4]; endsequence

  sel_hiz_a: assert property (sel_n |-> !miso_oe)
    else $error("output driven while deselected");
  pause_hiz_a: assert property (!sel_n && !pause_n |-> !miso_oe)
    else $error("output driven while paused");
  drive_on_a: assert property (!sel_n && pause_n |-> miso_oe)
    else $error("output not driven while selected");
  standby_on_a: assert property (idle_run |-> standby)
    else $error("standby missing while idle");
  standby_off_a: assert property (active_run |-> !standby)
    else $error("standby while selected or busy");
  guard_load_a: assert property (prot_open ##0 guard_wr |=> guard_ff == $past(block_guard_bits))
    else $error("guard bits not loaded");
  guard_freeze_a: assert property (prot_shut ##0 guard_wr |=> $stable(guard_ff))
    else $error("guard bits changed while frozen");
  job_hold_a: assert property (job_valid && !job_ready |=> job_valid && $stable(job_ff))
    else $error("job dropped before accepted");
  wdata_hold_a: assert property (wdata_valid && !wdata_ready |=> wdata_valid && $stable(wdata))
    else $error("page byte dropped before accepted");
  count_max_a: assert property (job_valid && job_ff.op == sfs_pkg::SFS_OP_PAGE_WRITE
                                |-> job_ff.count != 9'h000 && job_ff.count <= 9'h100)
    else $error("page count out of range");
  guard_area_a: assert property (job_valid && !is_full |-> !guarded)
    else $error("job issued into guarded sector");
  full_guard_a: assert property (job_valid && is_full |-> guard_ff == 3'h0)
    else $error("full wipe issued with guards set");
endmodule

bind sfs_front_end sfs_front_end_properties i_sfs_front_end_properties (
  .core_clk, .rst, .sel_n, .pause_n, .miso_oe, .protect_n, .block_guard_bits, .guard_wr,
  .guard_ff, .job_valid, .job_ready, .job_ff, .wdata_valid, .wdata_ready, .wdata,
  .array_busy, .standby
);

// ---- sim/sfs_master.sv ----
// sfs_master: behavioural link master, clock idle low or high, 15 ns period.
// assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module sfs_master (
  // link toward the device
  output logic spi_clk,
  output logic sel_n,
  output logic mosi,
  output logic pause_n,
  // data back from the device
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  // idle level of the serial clock; high selects the idle-high mode
  logic cpol = 1'b0;
  // select left low through power-up so no falling edge is seen
  initial begin
    spi_clk = 1'b0;
    sel_n = 1'b0;
    mosi = 1'b0;
    pause_n = 1'b1;
  end
  task automatic start();
    #10 spi_clk = cpol;
    #10 sel_n = 1'b0;
    #10;
  endtask
  // pause only ever raised inside a selected frame
  task automatic pause_gap();
    // kept off the clock edge so the fall just before still shifts out
    #4 pause_n = 1'b0;
    repeat (2) begin
      #7.5 mosi = ~mosi;
      spi_clk = 1'b1;
      #7.5 spi_clk = 1'b0;
    end
    #7.5 pause_n = 1'b1;
  endtask
  // bits go out msb first, read back at each rising edge
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    int i;
    for (i = 7; i >= 0; i--) begin
      if (i == hold_at) pause_gap();
      spi_clk = 1'b0;
      mosi = tx[i];
      #7.5 spi_clk = 1'b1;
      rx[i] = miso_o;
      #7.5 spi_clk = cpol;
    end
  endtask
  // released data line shows the inverse so a stale value never matches
  task automatic stop();
    #7.5 sel_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule

// ---- sim/tb.sv ----
// tb: self-checking bench for the serial flash front end.
// assumes sfs_master as link partner and the bound port checker.
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0, rst = 1'b1, protect_n = 1'b1, boost_level = 1'b0, guard_wr = 1'b0;
  logic job_ready = 1'b1, wdata_ready = 1'b1, array_busy = 1'b0;
  logic spi_clk, sel_n, mosi, pause_n, miso_o, miso_oe;
  logic job_valid, job_refused_ff, wdata_valid, standby;
  logic [2:0] block_guard_bits = 3'h0, guard_ff;
  logic [7:0] rd_data = 8'h00, wdata, rx;
  sfs_pkg::sfs_job_t job_ff, got;
  logic [7:0] wq[$];
  int error_cnt = 0, n_checks = 0, n_jobs = 0, n_ref = 0;

  always #25 core_clk = ~core_clk;
  sfs_front_end i_sfs_front_end (.core_clk, .rst, .spi_clk, .sel_n, .mosi, .pause_n, .miso_o,
    .miso_oe, .protect_n, .boost_level, .block_guard_bits, .guard_wr, .rd_data, .job_valid,
    .job_ready, .job_ff, .job_refused_ff, .wdata_valid, .wdata_ready, .wdata, .array_busy,
    .standby, .guard_ff);
  sfs_master i_sfs_master (.spi_clk, .sel_n, .mosi, .pause_n, .miso_o, .miso_oe);

  always @(posedge core_clk) begin
    if (wdata_valid && wdata_ready) wq.push_back(wdata);
    if (job_valid && job_ready) begin
      got <= job_ff;
      n_jobs <= n_jobs + 1;
    end
    if (job_refused_ff) n_ref <= n_ref + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  function automatic logic [7:0] dat(input int k);
    return k[7:0] ^ 8'h5A;
  endfunction
  // command, address msb first unless full wipe, then n data bytes
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input int hold);
    int k;
    i_sfs_master.start();
    i_sfs_master.xfer(op, -1, rx);
    if (op != sfs_pkg::CMD_FULL_WIPE)
      for (k = 2; k >= 0; k--) i_sfs_master.xfer(a[k*8 +: 8], -1, rx);
    for (k = 0; k < n; k++) i_sfs_master.xfer(dat(k), (k == 1) ? hold : -1, rx);
  endtask
  task automatic expect_job(input int n, input logic [1:0] op, input logic [23:0] a);
    int k;
    for (k = 0; k < 400 && n_jobs < n; k++) cyc(1);
    if (n_jobs < n) begin
      chk("job count", n, n_jobs);
      conclude();
    end else begin
      chk("job op", op, got.op);
      if (op != sfs_pkg::SFS_OP_FULL_WIPE) chk("job addr", a, got.addr);
    end
  endtask
  task automatic guard_load(input logic [2:0] g);
    cyc(1);
    block_guard_bits = g;
    guard_wr = 1'b1;
    cyc(1);
    guard_wr = 1'b0;
    cyc(2);
  endtask

  task automatic t_no_edge();
    i_sfs_master.xfer(sfs_pkg::CMD_FULL_WIPE, -1, rx);
    i_sfs_master.stop();
    cyc(20);
    chk("jobs before select edge", 0, n_jobs);
  endtask
  task automatic t_guard();
    guard_load(3'h1);
    chk("guard loaded", 1, guard_ff);
    protect_n = 1'b0;
    cyc(4);
    guard_load(3'h0);
    chk("guard frozen", 1, guard_ff);
    protect_n = 1'b1;
    cyc(4);
  endtask
  task automatic t_wipe();
    frame(sfs_pkg::CMD_ZONE_WIPE, 24'hFC0000, 0, -1);
    i_sfs_master.stop();
    cyc(20);
    chk("refused top sector", 1, n_ref);
    frame(sfs_pkg::CMD_ZONE_WIPE, 24'hF80000, 0, -1);
    i_sfs_master.stop();
    expect_job(1, sfs_pkg::SFS_OP_ZONE_WIPE, 24'hF80000);
    frame(sfs_pkg::CMD_FULL_WIPE, 24'h000000, 0, -1);
    i_sfs_master.stop();
    cyc(20);
    chk("refused full wipe", 2, n_ref);
    guard_load(3'h0);
    frame(sfs_pkg::CMD_FULL_WIPE, 24'h000000, 0, -1);
    i_sfs_master.stop();
    expect_job(2, sfs_pkg::SFS_OP_FULL_WIPE, 24'h000000);
  endtask
  task automatic t_page();
    int k;
    cyc(1);
    boost_level = 1'b1;
    wdata_ready = 1'b0;
    job_ready = 1'b0;
    wq.delete();
    frame(sfs_pkg::CMD_PAGE_WRITE, 24'h140300, 3, 4);
    i_sfs_master.stop();
    cyc(10);
    wdata_ready = 1'b1;
    cyc(20);
    chk("job held", 1, job_valid);
    job_ready = 1'b1;
    expect_job(3, sfs_pkg::SFS_OP_PAGE_WRITE, 24'h140300);
    chk("page count", 3, got.count);
    chk("fast flag", 1, got.fast);
    chk("page bytes", 3, wq.size());
    for (k = 0; k < 3; k++) chk("page byte", dat(k), wq[k]);
  endtask
  task automatic t_long();
    cyc(1);
    boost_level = 1'b0;
    wq.delete();
    frame(sfs_pkg::CMD_PAGE_WRITE, 24'h000000, 258, -1);
    i_sfs_master.stop();
    expect_job(4, sfs_pkg::SFS_OP_PAGE_WRITE, 24'h000000);
    chk("long count", 9'h100, got.count);
    chk("fast flag off", 0, got.fast);
    chk("long bytes", 256, wq.size());
  endtask
  task automatic t_read();
    cyc(1);
    rd_data = 8'hC3;
    array_busy = 1'b1;
    frame(sfs_pkg::CMD_READ, 24'h000010, 1, -1);
    chk("read byte", 8'hC3, rx);
    i_sfs_master.stop();
    cyc(20);
    chk("busy standby", 0, standby);
    chk("read makes no job", 4, n_jobs);
    array_busy = 1'b0;
    cyc(6);
    chk("idle standby", 1, standby);
  endtask
  task automatic t_idle_high();
    cyc(1);
    i_sfs_master.cpol = 1'b1;
    rd_data = 8'h96;
    frame(sfs_pkg::CMD_READ, 24'h000020, 1, -1);
    chk("read byte idle high", 8'h96, rx);
    i_sfs_master.stop();
    frame(sfs_pkg::CMD_ZONE_WIPE, 24'h0A0000, 0, -1);
    i_sfs_master.stop();
    expect_job(5, sfs_pkg::SFS_OP_ZONE_WIPE, 24'h0A0000);
  endtask

  initial begin
    cyc(10);
    rst = 1'b0;
    t_no_edge();
    t_guard();
    t_wipe();
    t_page();
    t_long();
    t_read();
    t_idle_high();
    conclude();
  end
endmodule
